// ==== inc/athacc_pkg.sv ====
// Functional notes
// - each new result with magnitude at or above threshold increments 8-bit hit count
// - a result below threshold decrements the hit count or clears it, as configured
// - comparator enable and below-threshold behaviour come from the configuration register
// - a read-only 32-bit sum adds each result while accumulation is enabled
// - the sum clears when accumulation is disabled or the channel is reconfigured
// - the sum-exceeded status flag sets when sum is strictly above the sum limit
// - sum-exceeded raises the interrupt only when its mask bit is set
// - the sum is compared with a 32-bit read/write limit register reset to zero
// - the comparator status bit sets when hit count equals its limit, raising the interrupt only when its mask bit is set
// - unipolar compares all sixteen threshold bits, two's complement only the low fifteen
// - writing channel control or mode register clears hit count and sum
package athacc_pkg;
    localparam int          RES_W = 16;
    localparam int          CNT_W = 8;
    localparam int          SUM_W = 32;
    localparam int          ADR_W = 32;
    // register byte addresses
    localparam logic [31:0] ADR_STATUS  = 32'hFFFF0500;
    localparam logic [31:0] ADR_MASK    = 32'hFFFF0504;
    localparam logic [31:0] ADR_MODE    = 32'hFFFF0508;
    localparam logic [31:0] ADR_CTRL    = 32'hFFFF050C;
    localparam logic [31:0] ADR_CONFIG  = 32'hFFFF0510;
    localparam logic [31:0] ADR_THRESH  = 32'hFFFF053C;
    localparam logic [31:0] ADR_HITLIM  = 32'hFFFF0540;
    localparam logic [31:0] ADR_HITCNT  = 32'hFFFF0544;
    localparam logic [31:0] ADR_SUM     = 32'hFFFF0548;
    localparam logic [31:0] ADR_SUMLIM  = 32'hFFFF054C;
    // status and mask bit positions
    localparam int          STA_W       = 3;
    localparam int          STA_READY   = 0;
    localparam int          STA_HIT     = 1;
    localparam int          STA_SUMEX   = 2;
    // configuration bit positions
    localparam int          CFG_W       = 3;
    localparam int          CFG_CMP_EN  = 0;
    localparam int          CFG_CMP_CLR = 1;
    localparam int          CFG_ACC_EN  = 2;
    // channel control: bit 0 selects unipolar coding
    localparam int          CTL_W       = 16;
    localparam int          CTL_UNIPOL  = 0;
    // reset values and the hit count ceiling
    localparam logic [15:0] RST_THRESH  = 16'h0000;
    localparam logic [7:0]  RST_HITLIM  = 8'h01;
    localparam logic [31:0] RST_SUMLIM  = 32'h00000000;
    localparam logic [7:0]  CNT_MAX     = 8'hFF;
    localparam logic [7:0]  CNT_ZERO    = 8'h00;
    localparam logic [31:0] SUM_ZERO    = 32'h00000000;
endpackage : athacc_pkg

// ==== inc/athacc_res_if.sv ====
`timescale 1ns/10ps
// carries each converter result and the reconfiguration clear to the post-processing units
interface athacc_res_if;
    logic        valid;
    logic [15:0] data;
    logic        unipolar;
    logic        clr;
    modport src (output valid, output data, output unipolar, output clr);
    modport snk (input valid, input data, input unipolar, input clr);
endinterface : athacc_res_if

// ==== src/athacc_hit_cnt.sv ====
`timescale 1ns/10ps
module athacc_hit_cnt (
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    athacc_res_if.snk              res,
    input  wire logic              i_en,
    input  wire logic              i_clr_mode,
    input  wire logic [15:0]       i_thresh,
    input  wire logic [7:0]        i_limit,
    output logic      [7:0]        o_count,
    output logic                   o_evt
);
    logic [15:0] mag;
    logic [15:0] thr;
    logic        ge;
    logic [7:0]  cnt_d;

    // magnitude; -32768 gives 32768 which still fits sixteen bits
    always_comb begin
        if (res.unipolar || !res.data[15]) begin
            mag = res.data;
        end else begin
            mag = 16'(~res.data + 16'h0001);
        end
        thr = res.unipolar ? i_thresh : {1'b0, i_thresh[14:0]};
        ge  = (mag >= thr);
    end

    // next count: up on a hit, down or cleared on a miss, pinned at both ends
    always_comb begin
        if (ge) begin
            cnt_d = (o_count == athacc_pkg::CNT_MAX) ? o_count : 8'(o_count + 8'h01);
        end else if (i_clr_mode) begin
            cnt_d = athacc_pkg::CNT_ZERO;
        end else begin
            cnt_d = (o_count == athacc_pkg::CNT_ZERO) ? o_count : 8'(o_count - 8'h01);
        end
    end

    // reconfiguration wins over a result landing in the same cycle
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_count <= athacc_pkg::CNT_ZERO;
            o_evt   <= 1'b0;
        end else if (res.clr) begin
            o_count <= athacc_pkg::CNT_ZERO;
            o_evt   <= 1'b0;
        end else if (res.valid && i_en) begin
            o_count <= cnt_d;
            o_evt   <= (cnt_d == i_limit);
        end else begin
            o_evt   <= 1'b0;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    a_hit_count_up: assert property (res.valid && i_en && !res.clr && ge && o_count != 8'hFF
        |=> o_count == 8'($past(o_count) + 8'h01)) else $error("hit count did not increment");
    a_hit_miss_clear: assert property (res.valid && i_en && !res.clr && !ge && i_clr_mode
        |=> o_count == 8'h00) else $error("hit count not cleared on miss");
    a_hit_no_wrap: assert property (o_count == 8'hFF && !res.clr ##1 o_count != 8'hFF
        |-> $past(res.valid) && !$past(ge)) else $error("hit count left saturation wrongly");
    a_hit_idle_hold: assert property (!i_en && !res.clr |=> $stable(o_count))
        else $error("hit count moved while comparator disabled");
    c_hit_saturate: cover property (o_count == 8'hFF ##1 o_count == 8'hFF);
endmodule : athacc_hit_cnt

// ==== src/athacc_sum.sv ====
`timescale 1ns/10ps
module athacc_sum (
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    athacc_res_if.snk              res,
    input  wire logic              i_en,
    input  wire logic [31:0]       i_limit,
    output logic      [31:0]       o_sum,
    output logic                   o_evt
);
    logic [31:0] ext;
    logic [31:0] sum_d;
    logic        over;

    // extend by coding, wrap on overflow; signed compare only for two's complement
    always_comb begin
        ext   = res.unipolar ? {16'h0000, res.data} : {{16{res.data[15]}}, res.data};
        sum_d = 32'(o_sum + ext);
        over  = res.unipolar ? (sum_d > i_limit) : ($signed(sum_d) > $signed(i_limit));
    end

    // accumulator register, cleared while disabled or on reconfiguration
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sum <= athacc_pkg::SUM_ZERO;
            o_evt <= 1'b0;
        end else if (res.clr || !i_en) begin
            o_sum <= athacc_pkg::SUM_ZERO;
            o_evt <= 1'b0;
        end else if (res.valid) begin
            o_sum <= sum_d;
            o_evt <= over;
        end else begin
            o_evt <= 1'b0;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    a_sum_adds: assert property (res.valid && i_en && !res.clr
        |=> o_sum == 32'($past(o_sum) + $past(ext))) else $error("sum did not add result");
    a_sum_disable_clr: assert property (!i_en || res.clr |=> o_sum == 32'h00000000)
        else $error("sum not cleared");
    a_sum_evt_cause: assert property (o_evt |-> $past(res.valid) && $past(over))
        else $error("sum event without exceeding result");
    c_sum_over: cover property (res.valid && i_en ##1 o_evt);
endmodule : athacc_sum

// ==== src/athacc_top.sv ====
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module athacc_top (
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    input  wire logic [31:0]       i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    input  wire logic              i_res_valid,
    input  wire logic [15:0]       i_res_data,
    output logic                   o_irq
);
    athacc_res_if res ();

    logic [15:0] thresh_q;
    logic [7:0]  hitlim_q;
    logic [31:0] sumlim_q;
    logic [2:0]  cfg_q;
    logic [2:0]  mask_q;
    logic [2:0]  status_q;
    logic [2:0]  status_set;
    logic [2:0]  status_clr;
    logic [15:0] ctrl_q;
    logic [15:0] mode_q;
    logic [7:0]  hit_count;
    logic [31:0] sum;
    logic        hit_evt;
    logic        sum_evt;
    logic [31:0] rd_d;
    logic        wr_status;

    // any write to control or mode counts as reconfiguring the channel
    assign res.valid    = i_res_valid;
    assign res.data     = i_res_data;
    assign res.unipolar = ctrl_q[athacc_pkg::CTL_UNIPOL];
    assign res.clr      = i_wr && (i_addr == athacc_pkg::ADR_CTRL
                                || i_addr == athacc_pkg::ADR_MODE);

    athacc_hit_cnt u_hit (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .res        (res),
        .i_en       (cfg_q[athacc_pkg::CFG_CMP_EN]),
        .i_clr_mode (cfg_q[athacc_pkg::CFG_CMP_CLR]),
        .i_thresh   (thresh_q),
        .i_limit    (hitlim_q),
        .o_count    (hit_count),
        .o_evt      (hit_evt)
    );

    athacc_sum u_sum (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .res        (res),
        .i_en       (cfg_q[athacc_pkg::CFG_ACC_EN]),
        .i_limit    (sumlim_q),
        .o_sum      (sum),
        .o_evt      (sum_evt)
    );

    // software-writable settings; the sum limit register is a full 32-bit word
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            thresh_q <= athacc_pkg::RST_THRESH;
            hitlim_q <= athacc_pkg::RST_HITLIM;
            sumlim_q <= athacc_pkg::RST_SUMLIM;
            cfg_q    <= '0;
            mask_q   <= '0;
        end else if (i_wr) begin
            if (i_addr == athacc_pkg::ADR_THRESH) begin
                thresh_q <= i_wdata[15:0];
            end
            if (i_addr == athacc_pkg::ADR_HITLIM) begin
                hitlim_q <= i_wdata[7:0];
            end
            if (i_addr == athacc_pkg::ADR_SUMLIM) begin
                sumlim_q <= i_wdata;
            end
            if (i_addr == athacc_pkg::ADR_CONFIG) begin
                cfg_q <= i_wdata[2:0];
            end
            if (i_addr == athacc_pkg::ADR_MASK) begin
                mask_q <= i_wdata[2:0];
            end
        end
    end

    // mode is stored only and control supplies only the unipolar bit; writing either also clears the counters
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_q <= '0;
            mode_q <= '0;
        end else if (i_wr) begin
            if (i_addr == athacc_pkg::ADR_CTRL) begin
                ctrl_q <= i_wdata[15:0];
            end
            if (i_addr == athacc_pkg::ADR_MODE) begin
                mode_q <= i_wdata[15:0];
            end
        end
    end

    // sticky events, write one to clear; a set in the clearing cycle survives
    always_comb begin
        wr_status                          = i_wr && (i_addr == athacc_pkg::ADR_STATUS);
        status_set                         = '0;
        status_set[athacc_pkg::STA_READY]  = i_res_valid;
        status_set[athacc_pkg::STA_HIT]    = hit_evt;
        status_set[athacc_pkg::STA_SUMEX]  = sum_evt;
        status_clr                         = wr_status ? i_wdata[2:0] : 3'h0;
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~status_clr) | status_set;
        end
    end

    // one level interrupt from the masked status bits
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((status_q & ~status_clr) | status_set) & mask_q);
        end
    end

    // read mux; unmapped addresses and reserved bits read as zero
    always_comb begin
        rd_d = 32'h00000000;
        unique case (i_addr)
            athacc_pkg::ADR_STATUS: rd_d = {29'h0, status_q};
            athacc_pkg::ADR_MASK:   rd_d = {29'h0, mask_q};
            athacc_pkg::ADR_MODE:   rd_d = {16'h0, mode_q};
            athacc_pkg::ADR_CTRL:   rd_d = {16'h0, ctrl_q};
            athacc_pkg::ADR_CONFIG: rd_d = {29'h0, cfg_q};
            athacc_pkg::ADR_THRESH: rd_d = {16'h0, thresh_q};
            athacc_pkg::ADR_HITLIM: rd_d = {24'h0, hitlim_q};
            athacc_pkg::ADR_HITCNT: rd_d = {24'h0, hit_count};
            athacc_pkg::ADR_SUM:    rd_d = sum;
            athacc_pkg::ADR_SUMLIM: rd_d = sumlim_q;
            default:                rd_d = 32'h00000000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_rd ? rd_d : 32'h00000000;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    // a same-cycle write-one-clear of the flag may legally drop the interrupt
    a_irq_masked_sum: assert property (status_q[2] && mask_q[2] && !(wr_status && i_wdata[2])
        |=> o_irq)
        else $error("masked sum event gave no interrupt");
    a_irq_gate_off: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !o_irq)
        else $error("interrupt with all masks off");
    a_sumex_sticky: assert property (status_q[2] && !(wr_status && i_wdata[2])
        |=> status_q[2]) else $error("sum-exceeded flag dropped by itself");
    a_hit_status_set: assert property (hit_evt |=> status_q[1])
        else $error("comparator status bit not set");
    a_recfg_clears: assert property (res.clr |=> hit_count == 8'h00 && sum == 32'h00000000)
        else $error("reconfiguration did not clear counters");
    a_read_one_cycle: assert property (!i_rd |=> o_rdata == 32'h00000000)
        else $error("read data outside read cycle");
    a_ready_flag: assert property (i_res_valid |=> status_q[0])
        else $error("ready flag not set by result");
    c_irq_raised: cover property (!o_irq ##1 o_irq);
    c_recfg: cover property (res.clr ##1 i_res_valid);
endmodule : athacc_top

// ==== tb/athacc_conv_model.sv ====
`timescale 1ns/10ps
// converter stand-in: one result per request, handed over at once or after a slow conversion
module athacc_conv_model (
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_req,
    input  wire logic        i_slow,
    input  wire logic [15:0] i_data,
    output logic             o_valid,
    output logic      [15:0] o_data
);
    logic [15:0] hold_q;
    logic [1:0]  wait_q;
    // idle data toggles every cycle so the block cannot lean on a stale result
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_valid <= 1'b0;
            o_data  <= 16'h0000;
            hold_q  <= 16'h0000;
            wait_q  <= 2'h0;
        end else begin
            o_valid <= 1'b0;
            o_data  <= ~o_data;
            if (i_req && !i_slow) begin
                o_valid <= 1'b1;
                o_data  <= i_data;
            end else if (i_req) begin
                hold_q <= i_data;
                wait_q <= 2'h3;
            end else if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
                if (wait_q == 2'h1) begin
                    o_valid <= 1'b1;
                    o_data  <= hold_q;
                end
            end
        end
    end
endmodule : athacc_conv_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    logic        i_mclk    = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [31:0] i_addr    = 32'h00000000;
    logic [31:0] i_wdata   = 32'h00000000;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic        req       = 1'b0;
    logic        slow      = 1'b0;
    logic [15:0] rq_d      = 16'h0000;
    logic [31:0] o_rdata;
    logic        o_irq;
    logic        res_v;
    logic [15:0] res_d;
    int          err_total = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          m_cnt, m_thr, m_cfg, m_ctl, m_mode, m_msk, m_sta, m_lim = 1;
    bit   [31:0] m_sum, m_slim;
    logic [31:0] adrs [11] = '{athacc_pkg::ADR_STATUS, athacc_pkg::ADR_MASK, athacc_pkg::ADR_MODE,
        athacc_pkg::ADR_CTRL, athacc_pkg::ADR_CONFIG, athacc_pkg::ADR_THRESH, athacc_pkg::ADR_HITLIM,
        athacc_pkg::ADR_HITCNT, athacc_pkg::ADR_SUM, athacc_pkg::ADR_SUMLIM, 32'hFFFF0550};

    always #10 i_mclk = ~i_mclk;

    athacc_conv_model u_conv (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req(req), .i_slow(slow),
        .i_data(rq_d), .o_valid(res_v), .o_data(res_d));
    athacc_top u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_res_valid(res_v), .i_res_data(res_d),
        .o_irq(o_irq));

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] exp_rd(input logic [31:0] a);
        case (a)
            athacc_pkg::ADR_STATUS: return m_sta;
            athacc_pkg::ADR_MASK:   return m_msk;
            athacc_pkg::ADR_MODE:   return m_mode;
            athacc_pkg::ADR_CTRL:   return m_ctl;
            athacc_pkg::ADR_CONFIG: return m_cfg;
            athacc_pkg::ADR_THRESH: return m_thr;
            athacc_pkg::ADR_HITLIM: return m_lim;
            athacc_pkg::ADR_HITCNT: return m_cnt;
            athacc_pkg::ADR_SUM:    return m_sum;
            athacc_pkg::ADR_SUMLIM: return m_slim;
            default:                return 32'h00000000;
        endcase
    endfunction : exp_rd

    // reference update for every result the block really takes
    always @(posedge i_mclk) begin
        int mag;
        int thr;
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            final_report();
        end
        if (!i_sys_rst && res_v) begin
            mag = (m_ctl[0] || !res_d[15]) ? int'(res_d) : 65536 - int'(res_d);
            thr = m_ctl[0] ? m_thr : m_thr & 32'h7FFF;
            m_sta |= 1;
            if (m_cfg[0]) begin
                if (mag >= thr) m_cnt = (m_cnt == 255) ? 255 : m_cnt + 1;
                else m_cnt = m_cfg[1] ? 0 : ((m_cnt == 0) ? 0 : m_cnt - 1);
                if (m_cnt == m_lim) m_sta |= 2;
            end
            if (m_cfg[2]) begin
                m_sum += m_ctl[0] ? {16'h0000, res_d} : {{16{res_d[15]}}, res_d};
                if (m_ctl[0] ? (m_sum > m_slim) : ($signed(m_sum) > $signed(m_slim)))
                    m_sta |= 4;
            end
        end
    end

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        case (a)
            athacc_pkg::ADR_STATUS: m_sta &= ~int'(d[2:0]);
            athacc_pkg::ADR_MASK:   m_msk = d[2:0];
            athacc_pkg::ADR_CONFIG: m_cfg = d[2:0];
            athacc_pkg::ADR_THRESH: m_thr = d[15:0];
            athacc_pkg::ADR_HITLIM: m_lim = d[7:0];
            athacc_pkg::ADR_SUMLIM: m_slim = d;
            default: ;
        endcase
        if (a == athacc_pkg::ADR_MODE) m_mode = d[15:0];
        if (a == athacc_pkg::ADR_CTRL) m_ctl = d[15:0];
        if (a == athacc_pkg::ADR_MODE || a == athacc_pkg::ADR_CTRL) m_cnt = 0;
        if (a == athacc_pkg::ADR_MODE || a == athacc_pkg::ADR_CTRL || !m_cfg[2]) m_sum = 0;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), o_rdata, exp_rd(a));
    endtask : rd

    task automatic send(input logic [15:0] d, input logic s);
        @(posedge i_mclk);
        req  <= 1'b1;
        rq_d <= d;
        slow <= s;
        @(posedge i_mclk);
        req <= 1'b0;
        repeat (8) @(posedge i_mclk);
        #1 chk("irq", {31'h0, o_irq}, {31'h0, (m_sta & m_msk) != 0});
        rd(athacc_pkg::ADR_HITCNT);
        rd(athacc_pkg::ADR_SUM);
        rd(athacc_pkg::ADR_STATUS);
    endtask : send

    initial begin
        logic [15:0] d;
        void'($urandom(32'h5B35619E));
        repeat (12) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        foreach (adrs[k]) rd(adrs[k]);
        // random writes everywhere, read-only places must ignore them
        foreach (adrs[k]) wr(adrs[k], $urandom);
        foreach (adrs[k]) rd(adrs[k]);
        wr(athacc_pkg::ADR_MASK, 32'h00000007);
        // two's complement decrement, two's complement clear, then unipolar
        for (int i = 0; i < 3; i++) begin
            wr(athacc_pkg::ADR_CTRL, (i == 2) ? 32'h1 : 32'h0);
            wr(athacc_pkg::ADR_CONFIG, (i == 1) ? 32'h7 : 32'h5);
            wr(athacc_pkg::ADR_THRESH, {1'($urandom_range(0, 1)), 15'($urandom_range(0, 3000))});
            wr(athacc_pkg::ADR_HITLIM, $urandom_range(2, 6));
            wr(athacc_pkg::ADR_SUMLIM, $urandom_range(0, 60000));
            wr(athacc_pkg::ADR_STATUS, 32'h00000007);
            for (int k = 0; k < 14; k++) begin
                d = 16'($urandom_range(0, 6000));
                if ($urandom_range(0, 1) == 1) d = -d;
                if (k % 5 == 4) d = (k % 2) ? 16'h8000 : 16'(m_thr);
                send(d, 1'($urandom_range(0, 1)));
            end
        end
        // back-to-back hits, count must stop at its ceiling
        wr(athacc_pkg::ADR_CONFIG, 32'h00000001);
        wr(athacc_pkg::ADR_THRESH, 32'h00000000);
        wr(athacc_pkg::ADR_HITLIM, 32'h000000C8);
        for (int k = 0; k < 260; k++) begin
            @(posedge i_mclk);
            req  <= 1'b1;
            rq_d <= 16'($urandom);
            slow <= 1'b0;
        end
        send(16'h0001, 1'b0);
        // exceeded flag must outlive a falling sum until cleared; signed coding lets it fall
        wr(athacc_pkg::ADR_CTRL, 32'h00000000);
        wr(athacc_pkg::ADR_CONFIG, 32'h00000005);
        wr(athacc_pkg::ADR_SUMLIM, 32'h0000000A);
        wr(athacc_pkg::ADR_STATUS, 32'h00000007);
        send(16'h0014, 1'b0);
        send(16'hFFE2, 1'b1);
        wr(athacc_pkg::ADR_MASK, 32'h00000003);
        send(16'hFFFF, 1'b0);
        wr(athacc_pkg::ADR_STATUS, 32'h00000004);
        send(16'h0003, 1'b0);
        // comparator off holds the count; accumulation off, then each reconfiguration, clears the sum
        wr(athacc_pkg::ADR_CONFIG, 32'h00000000);
        send(16'h0005, 1'b0);
        wr(athacc_pkg::ADR_CONFIG, 32'h00000005);
        send(16'h0005, 1'b0);
        wr(athacc_pkg::ADR_MODE, $urandom);
        rd(athacc_pkg::ADR_SUM);
        send(16'h0009, 1'b0);
        wr(athacc_pkg::ADR_CTRL, 32'h00000000);
        rd(athacc_pkg::ADR_SUM);
        rd(athacc_pkg::ADR_HITCNT);
        final_report();
    end
endmodule : tb_top
